/* hw/carf_consts.svh */
// Constants of the architectural register file: indices, field positions, reset values.
`ifndef CARF_CONSTS_SVH
`define CARF_CONSTS_SVH
`define CARF_GPR_COUNT 8
`define CARF_GPR_SPLIT 4
`define CARF_SEG_COUNT 6
`define CARF_CTL_COUNT 3
`define CARF_SYS_COUNT 4
`define CARF_DBG_COUNT 6
`define CARF_TST_COUNT 2
`define CARF_BKP_COUNT 4
`define CARF_QUEUE_DEPTH 4
`define CARF_LEGACY_FLAGS_W 16
`define CARF_PROTECT_BIT 0
`define CARF_CTL_MODE 2'h0
`define CARF_CTL_FAULT 2'h1
`define CARF_CTL_PGDIR 2'h2
`define CARF_FLAGS_RESET 32'h00000002
`define CARF_IP_RESET 32'h0000FFF0
`define CARF_ZERO32 32'h00000000
`endif

/* hw/carf_pkg.sv */
// Types shared by the architectural register file.
package carf_pkg;
	typedef enum logic [1:0] {CARF_VIEW_WORD, CARF_VIEW_HALF, CARF_VIEW_LOW_BYTE,
		CARF_VIEW_HIGH_BYTE} carf_view_t;
	typedef enum logic [2:0] {CARF_SH_SHL, CARF_SH_SHR, CARF_SH_SAR, CARF_SH_ROL,
		CARF_SH_ROR} carf_shift_op_t;
	typedef enum logic [1:0] {CARF_SYS_GLOBAL, CARF_SYS_VECTOR, CARF_SYS_LOCAL,
		CARF_SYS_TASK} carf_sys_sel_t;
endpackage : carf_pkg

/* hw/carf_register_file.sv */
// Architectural register file of the processor core.
`timescale 1ns/1ps
`include "carf_consts.svh"
// Summary of operation
// RULE_01 - Eight 32-bit general registers serve both address computation and data operands.
// RULE_02 - The first four general registers can be accessed as word, low half, or either byte.
// RULE_03 - Six 16-bit segment selectors name the currently addressable segments.
// RULE_04 - The 32-bit instruction pointer drives fetching and advances after each instruction.
// RULE_05 - The 32-bit status word carries the legacy 16-bit flags word in bits 0 to 15.
// RULE_06 - Three 32-bit control registers hold mode bits and the two paging registers.
// RULE_07 - A 64-bit barrel shifter serves shift, rotate, multiply and divide steps.
// RULE_08 - Decoded instructions wait in a queue until the execution unit takes them.
// RULE_09 - The core runs in real address mode or in protected virtual address mode.
// RULE_10 - Four system address registers locate the global, vector and local tables and the task.
// RULE_11 - Six debug registers are readable and writable by software.
// RULE_12 - Two test registers steer tests of the translation cache arrays.
// RULE_13 - Four breakpoint addresses are held and flag matches on fetch or data access.
// RULE_14 - The protect enable bit is set by either load but cleared only by a full load.
// RULE_15 - A sub-view write changes only the addressed bits of a general register.
module carf_register_file (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// General register port
	input wire logic gpr_wr_en,
	input wire logic [2:0] gpr_wr_idx,
	input wire carf_pkg::carf_view_t gpr_wr_view,
	input wire logic [31:0] gpr_wr_data,
	input wire logic [2:0] gpr_rd_idx,
	input wire carf_pkg::carf_view_t gpr_rd_view,
	output logic [31:0] gpr_rd_data,
	output logic [31:0] accumulator_gpr,
	output logic [31:0] base_gpr,
	output logic [31:0] count_gpr,
	output logic [31:0] data_ext_gpr,
	// Segment selectors
	input wire logic seg_wr_en,
	input wire logic [2:0] seg_wr_idx,
	input wire logic [15:0] seg_wr_data,
	input wire logic [2:0] seg_rd_idx,
	output logic [15:0] seg_rd_data,
	// Instruction pointer and status word
	input wire logic instr_done,
	input wire logic [3:0] instr_len,
	input wire logic ip_load_en,
	input wire logic [31:0] ip_load_data,
	output logic [31:0] instr_pointer,
	input wire logic flags_wr_en,
	input wire logic flags_wr_legacy,
	input wire logic [31:0] flags_wr_data,
	output logic [31:0] extended_status_word,
	output logic [15:0] legacy_status_word,
	// Control registers
	input wire logic ctl_wr_en,
	input wire logic [1:0] ctl_wr_idx,
	input wire logic [31:0] ctl_wr_data,
	input wire logic load_low_word_instr,
	input wire logic [15:0] low_word_data,
	output logic [31:0] mode_control_reg,
	output logic [31:0] fault_address_reg,
	output logic [31:0] page_dir_base_reg,
	output logic protect_enable_bit,
	output logic real_mode,
	// System address registers
	input wire logic sys_wr_en,
	input wire carf_pkg::carf_sys_sel_t sys_wr_sel,
	input wire logic [31:0] sys_wr_data,
	output logic [31:0] global_table_pointer,
	output logic [31:0] vector_table_pointer,
	output logic [31:0] local_table_pointer,
	output logic [31:0] task_state_pointer,
	// Debug and test registers
	input wire logic dbg_wr_en,
	input wire logic [2:0] dbg_idx,
	input wire logic [31:0] dbg_wr_data,
	output logic [31:0] dbg_rd_data,
	input wire logic tst_wr_en,
	input wire logic tst_idx,
	input wire logic [31:0] tst_wr_data,
	output logic [31:0] tst_cmd,
	output logic [31:0] tst_data,
	// Breakpoint match
	input wire logic [31:0] watch_addr,
	input wire logic watch_is_fetch,
	input wire logic watch_valid,
	output logic [3:0] bkp_hit,
	// Barrel shifter
	input wire logic [63:0] sh_data,
	input wire logic [5:0] sh_amount,
	input wire carf_pkg::carf_shift_op_t sh_op,
	output logic [63:0] sh_result,
	// Decoded instruction queue
	input wire logic dq_push_valid,
	input wire logic [31:0] dq_push_data,
	output logic dq_push_ready,
	output logic dq_pop_valid,
	input wire logic dq_pop_ready,
	output logic [31:0] dq_pop_data
);
	import carf_pkg::*;

	// ==========================================================
	// General registers
	logic [31:0] gpr_reg [`CARF_GPR_COUNT];

	// Only the four split-capable registers honour byte-view writes.
	genvar gi;
	generate
		for (gi = 0; gi < `CARF_GPR_COUNT; gi++) begin : g_gpr
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					gpr_reg[gi] <= `CARF_ZERO32;
				end else if (gpr_wr_en && gpr_wr_idx == 3'(gi)) begin // see RULE_01
					case (gpr_wr_view) // see RULE_15
						CARF_VIEW_WORD: gpr_reg[gi] <= gpr_wr_data;
						CARF_VIEW_HALF: gpr_reg[gi][15:0] <= gpr_wr_data[15:0];
						CARF_VIEW_LOW_BYTE: begin
							if (gi < `CARF_GPR_SPLIT) begin // see RULE_02
								gpr_reg[gi][7:0] <= gpr_wr_data[7:0];
							end
						end
						CARF_VIEW_HIGH_BYTE: begin
							if (gi < `CARF_GPR_SPLIT) begin // see RULE_02
								gpr_reg[gi][15:8] <= gpr_wr_data[7:0];
							end
						end
						default: gpr_reg[gi] <= gpr_reg[gi];
					endcase
				end
			end
		end
	endgenerate

	always_comb begin
		case (gpr_rd_view) // see RULE_02
			CARF_VIEW_WORD: gpr_rd_data = gpr_reg[gpr_rd_idx];
			CARF_VIEW_HALF: gpr_rd_data = {16'h0000, gpr_reg[gpr_rd_idx][15:0]};
			CARF_VIEW_LOW_BYTE: gpr_rd_data = {24'h000000, gpr_reg[gpr_rd_idx][7:0]};
			CARF_VIEW_HIGH_BYTE: gpr_rd_data = {24'h000000, gpr_reg[gpr_rd_idx][15:8]};
			default: gpr_rd_data = gpr_reg[gpr_rd_idx];
		endcase
	end
	assign accumulator_gpr = gpr_reg[0];
	assign base_gpr = gpr_reg[1];
	assign count_gpr = gpr_reg[2];
	assign data_ext_gpr = gpr_reg[3];

	// ==========================================================
	// Segment selectors
	logic [15:0] seg_reg [`CARF_SEG_COUNT];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `CARF_SEG_COUNT; i++) seg_reg[i] <= 16'h0000;
		end else if (seg_wr_en && seg_wr_idx < 3'(`CARF_SEG_COUNT)) begin // see RULE_03
			seg_reg[seg_wr_idx] <= seg_wr_data;
		end
	end
	// Out-of-range indices read zero rather than wrap onto a real selector.
	assign seg_rd_data = (seg_rd_idx < 3'(`CARF_SEG_COUNT)) ? seg_reg[seg_rd_idx] : 16'h0000;

	// ==========================================================
	// Instruction pointer and status word
	logic [31:0] ip_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ip_reg <= `CARF_IP_RESET;
		end else if (ip_load_en) begin
			ip_reg <= ip_load_data;
		end else if (instr_done) begin // see RULE_04
			ip_reg <= ip_reg + {28'h0000000, instr_len};
		end
	end
	assign instr_pointer = ip_reg;

	logic [31:0] flags_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_reg <= `CARF_FLAGS_RESET;
		end else if (flags_wr_en && flags_wr_legacy) begin // see RULE_05
			flags_reg[`CARF_LEGACY_FLAGS_W-1:0] <= flags_wr_data[`CARF_LEGACY_FLAGS_W-1:0];
		end else if (flags_wr_en) begin
			flags_reg <= flags_wr_data;
		end
	end
	assign extended_status_word = flags_reg;
	assign legacy_status_word = flags_reg[`CARF_LEGACY_FLAGS_W-1:0]; // see RULE_05

	// ==========================================================
	// Control registers
	logic [31:0] ctl_reg [`CARF_CTL_COUNT];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `CARF_CTL_COUNT; i++) ctl_reg[i] <= `CARF_ZERO32;
		end else if (ctl_wr_en && ctl_wr_idx < 2'(`CARF_CTL_COUNT)) begin // see RULE_06
			ctl_reg[ctl_wr_idx] <= ctl_wr_data;
		end else if (load_low_word_instr) begin
			// The low-word load may raise protect enable but can never drop it.
			ctl_reg[`CARF_CTL_MODE][15:0] <= low_word_data |
				{15'h0000, ctl_reg[`CARF_CTL_MODE][`CARF_PROTECT_BIT]}; // see RULE_14
		end
	end
	assign mode_control_reg = ctl_reg[`CARF_CTL_MODE];
	assign fault_address_reg = ctl_reg[`CARF_CTL_FAULT];
	assign page_dir_base_reg = ctl_reg[`CARF_CTL_PGDIR];
	assign protect_enable_bit = ctl_reg[`CARF_CTL_MODE][`CARF_PROTECT_BIT]; // see RULE_09
	assign real_mode = ~protect_enable_bit; // see RULE_09

	// ==========================================================
	// System address registers
	logic [31:0] sys_reg [`CARF_SYS_COUNT];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `CARF_SYS_COUNT; i++) sys_reg[i] <= `CARF_ZERO32;
		end else if (sys_wr_en) begin // see RULE_10
			sys_reg[sys_wr_sel] <= sys_wr_data;
		end
	end
	assign global_table_pointer = sys_reg[CARF_SYS_GLOBAL];
	assign vector_table_pointer = sys_reg[CARF_SYS_VECTOR];
	assign local_table_pointer = sys_reg[CARF_SYS_LOCAL];
	assign task_state_pointer = sys_reg[CARF_SYS_TASK];

	// ==========================================================
	// Debug, test and breakpoint registers
	logic [31:0] dbg_reg [`CARF_DBG_COUNT];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `CARF_DBG_COUNT; i++) dbg_reg[i] <= `CARF_ZERO32;
		end else if (dbg_wr_en && dbg_idx < 3'(`CARF_DBG_COUNT)) begin // see RULE_11
			dbg_reg[dbg_idx] <= dbg_wr_data;
		end
	end
	assign dbg_rd_data = (dbg_idx < 3'(`CARF_DBG_COUNT)) ? dbg_reg[dbg_idx] : `CARF_ZERO32;

	// Debug register 4 enables the breakpoints: bit 2n enables, bit 2n+1 picks data accesses.
	genvar bi;
	generate
		for (bi = 0; bi < `CARF_BKP_COUNT; bi++) begin : g_bkp
			assign bkp_hit[bi] = watch_valid && dbg_reg[4][2*bi] &&
				(dbg_reg[bi] == watch_addr) &&
				(dbg_reg[4][2*bi+1] != watch_is_fetch); // see RULE_13
		end
	endgenerate

	logic [31:0] tst_reg [`CARF_TST_COUNT];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `CARF_TST_COUNT; i++) tst_reg[i] <= `CARF_ZERO32;
		end else if (tst_wr_en) begin // see RULE_12
			tst_reg[tst_idx] <= tst_wr_data;
		end
	end
	assign tst_cmd = tst_reg[0];
	assign tst_data = tst_reg[1];

	// ==========================================================
	// Barrel shifter
	always_comb begin
		case (sh_op) // see RULE_07
			CARF_SH_SHL: sh_result = sh_data << sh_amount;
			CARF_SH_SHR: sh_result = sh_data >> sh_amount;
			CARF_SH_SAR: sh_result = 64'($signed(sh_data) >>> sh_amount);
			CARF_SH_ROL: sh_result = (sh_data << sh_amount) | (sh_data >> (7'h40 - 7'(sh_amount)));
			CARF_SH_ROR: sh_result = (sh_data >> sh_amount) | (sh_data << (7'h40 - 7'(sh_amount)));
			default: sh_result = sh_data;
		endcase
	end

	// ==========================================================
	// Decoded instruction queue
	logic [31:0] dq_mem [`CARF_QUEUE_DEPTH];
	logic [1:0] dq_wr_reg;
	logic [1:0] dq_rd_reg;
	logic [2:0] dq_cnt_reg;
	logic dq_push;
	logic dq_pop;
	assign dq_push_ready = dq_cnt_reg < 3'(`CARF_QUEUE_DEPTH);
	assign dq_pop_valid = dq_cnt_reg != 3'h0;
	assign dq_push = dq_push_valid && dq_push_ready;
	assign dq_pop = dq_pop_valid && dq_pop_ready;
	assign dq_pop_data = dq_mem[dq_rd_reg];
	always_ff @(posedge clk) begin
		if (dq_push) begin // see RULE_08
			dq_mem[dq_wr_reg] <= dq_push_data;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dq_wr_reg <= 2'h0;
			dq_rd_reg <= 2'h0;
			dq_cnt_reg <= 3'h0;
		end else begin
			if (dq_push) dq_wr_reg <= dq_wr_reg + 2'h1;
			if (dq_pop) dq_rd_reg <= dq_rd_reg + 2'h1;
			dq_cnt_reg <= dq_cnt_reg + {2'h0, dq_push} - {2'h0, dq_pop}; // see RULE_08
		end
	end

	// ==========================================================
	// Checks
	sequence s_low_load;
		load_low_word_instr && !ctl_wr_en;
	endsequence
	AST_IP_ADVANCE: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_04
		instr_done && !ip_load_en |=> instr_pointer == $past(instr_pointer) + 32'($past(instr_len)))
		else $error("Instruction pointer did not advance by the length.");
	AST_PE_STICKY: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_14
		protect_enable_bit and s_low_load |=> protect_enable_bit)
		else $error("Low-word load cleared protect enable.");
	AST_PE_SET_LOW: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_14
		s_low_load and low_word_data[0] |=> protect_enable_bit)
		else $error("Low-word load failed to set protect enable.");
	AST_HALF_KEEPS_TOP: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_15
		gpr_wr_en && gpr_wr_view != CARF_VIEW_WORD && gpr_wr_idx == 3'h0
		|=> accumulator_gpr[31:16] == $past(accumulator_gpr[31:16]))
		else $error("Sub-view write touched the upper half.");
	AST_HIGH_BYTE: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_02
		gpr_wr_en && gpr_wr_view == CARF_VIEW_HIGH_BYTE && gpr_wr_idx == 3'h1
		|=> base_gpr[15:8] == $past(gpr_wr_data[7:0]) && base_gpr[7:0] == $past(base_gpr[7:0]))
		else $error("High-byte write landed wrongly.");
	AST_LEGACY_VIEW: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_05
		flags_wr_en && flags_wr_legacy
		|=> extended_status_word[31:16] == $past(extended_status_word[31:16]))
		else $error("Legacy flags write changed the upper flags.");
	AST_MODE_PAIR: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_09
		ctl_wr_en && ctl_wr_idx == `CARF_CTL_MODE
		|=> real_mode == !$past(ctl_wr_data[`CARF_PROTECT_BIT]))
		else $error("Real mode did not follow the loaded protect enable bit.");
	AST_FULL_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_06
		ctl_wr_en && ctl_wr_idx == `CARF_CTL_MODE && !ctl_wr_data[0] |=> !protect_enable_bit)
		else $error("Full load did not clear protect enable.");
	AST_QUEUE_BOUND: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_08
		dq_cnt_reg == 3'(`CARF_QUEUE_DEPTH) && !dq_pop |=> !dq_push_ready)
		else $error("Queue accepted beyond its depth.");
endmodule : carf_register_file

/* verif/carf_register_file_tb.sv */
// Self-checking testbench of the architectural register file.
`timescale 1ns/1ps
`include "carf_consts.svh"
module carf_register_file_tb;
	import carf_pkg::*;
	// ==========================================================
	// Signals
	logic clk, rst_n, gpr_wr_en, seg_wr_en, instr_done, ip_load_en, flags_wr_en, flags_wr_legacy;
	logic [2:0] gpr_wr_idx, gpr_rd_idx, seg_wr_idx, seg_rd_idx, dbg_idx;
	carf_view_t gpr_wr_view, gpr_rd_view;
	logic [31:0] gpr_wr_data, gpr_rd_data, accumulator_gpr, base_gpr, count_gpr, data_ext_gpr;
	logic [15:0] seg_wr_data, seg_rd_data, legacy_status_word, low_word_data;
	logic [3:0] instr_len, bkp_hit;
	logic [31:0] ip_load_data, instr_pointer, flags_wr_data, extended_status_word;
	logic ctl_wr_en, load_low_word_instr, protect_enable_bit, real_mode, sys_wr_en;
	logic [1:0] ctl_wr_idx;
	logic [31:0] ctl_wr_data, mode_control_reg, fault_address_reg, page_dir_base_reg, sys_wr_data;
	carf_sys_sel_t sys_wr_sel;
	logic [31:0] global_table_pointer, vector_table_pointer, local_table_pointer, task_state_pointer;
	logic dbg_wr_en, tst_wr_en, tst_idx, watch_is_fetch, watch_valid;
	logic [31:0] dbg_wr_data, dbg_rd_data, tst_wr_data, tst_cmd, tst_data, watch_addr;
	logic [63:0] sh_data, sh_result;
	logic [5:0] sh_amount;
	carf_shift_op_t sh_op;
	logic dq_push_valid, dq_push_ready, dq_pop_valid, dq_pop_ready;
	logic [31:0] dq_push_data, dq_pop_data;
	int fail_count, n_checks, i, k;
	logic [31:0] seed = 32'h97A1A88D;
	logic [31:0] g [8];
	logic [15:0] s [8];
	logic [31:0] d [8];
	logic [31:0] p [4];
	logic [31:0] r, e, m;

	carf_register_file dut (.clk, .rst_n, .gpr_wr_en, .gpr_wr_idx, .gpr_wr_view, .gpr_wr_data,
		.gpr_rd_idx, .gpr_rd_view, .gpr_rd_data, .accumulator_gpr, .base_gpr, .count_gpr,
		.data_ext_gpr, .seg_wr_en, .seg_wr_idx, .seg_wr_data, .seg_rd_idx, .seg_rd_data,
		.instr_done, .instr_len, .ip_load_en, .ip_load_data, .instr_pointer, .flags_wr_en,
		.flags_wr_legacy, .flags_wr_data, .extended_status_word, .legacy_status_word, .ctl_wr_en,
		.ctl_wr_idx, .ctl_wr_data, .load_low_word_instr, .low_word_data, .mode_control_reg,
		.fault_address_reg, .page_dir_base_reg, .protect_enable_bit, .real_mode, .sys_wr_en,
		.sys_wr_sel, .sys_wr_data, .global_table_pointer, .vector_table_pointer,
		.local_table_pointer, .task_state_pointer, .dbg_wr_en, .dbg_idx, .dbg_wr_data,
		.dbg_rd_data, .tst_wr_en, .tst_idx, .tst_wr_data, .tst_cmd, .tst_data, .watch_addr,
		.watch_is_fetch, .watch_valid, .bkp_hit, .sh_data, .sh_amount, .sh_op, .sh_result,
		.dq_push_valid, .dq_push_data, .dq_push_ready, .dq_pop_valid, .dq_pop_ready, .dq_pop_data);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [31:0] upd(logic [31:0] o, carf_view_t v, logic [31:0] w, int x);
		case (v)
			CARF_VIEW_WORD: return w;
			CARF_VIEW_HALF: return {o[31:16], w[15:0]};
			CARF_VIEW_LOW_BYTE: return (x < 4) ? {o[31:8], w[7:0]} : o;
			default: return (x < 4) ? {o[31:16], w[7:0], o[7:0]} : o;
		endcase
	endfunction : upd
	function automatic logic [31:0] rdv(logic [31:0] o, carf_view_t v);
		case (v)
			CARF_VIEW_WORD: return o;
			CARF_VIEW_HALF: return {16'h0000, o[15:0]};
			CARF_VIEW_LOW_BYTE: return {24'h000000, o[7:0]};
			default: return {24'h000000, o[15:8]};
		endcase
	endfunction : rdv
	function automatic logic [63:0] shx(logic [63:0] v, logic [5:0] a, carf_shift_op_t o);
		case (o)
			CARF_SH_SHL: return v << a;
			CARF_SH_SHR: return v >> a;
			CARF_SH_SAR: return $signed(v) >>> a;
			CARF_SH_ROL: return (v << a) | (v >> (7'h40 - {1'b0, a}));
			default: return (v >> a) | (v << (7'h40 - {1'b0, a}));
		endcase
	endfunction : shx
	// Enable pairs sit in debug register four: even bit enables, odd bit picks data over fetch.
	function automatic logic [3:0] bkx(logic [31:0] a, logic f, logic vld);
		logic [3:0] h;
		for (int n = 0; n < 4; n++) begin
			h[n] = vld & d[4][2*n] & (a == d[n]) & (d[4][2*n+1] ? ~f : f);
		end
		return h;
	endfunction : bkx
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic step();
		@(posedge clk);
		@(negedge clk);
	endtask : step
	task automatic ctl(input logic we, input logic [1:0] x, input logic [31:0] w, input logic lw,
		input logic [15:0] lwd, input logic [31:0] em);
		ctl_wr_en = we;
		ctl_wr_idx = x;
		ctl_wr_data = w;
		load_low_word_instr = lw;
		low_word_data = lwd;
		step();
		chk(mode_control_reg, em, "mode control");
		chk(protect_enable_bit, em[0], "protect enable");
		chk(real_mode, {63'h0, ~em[0]}, "real mode");
	endtask : ctl
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#50000;
		fail_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		report_and_stop();
	end

	// ==========================================================
	// Main sequence
	initial begin
		{rst_n, gpr_wr_en, seg_wr_en, instr_done, ip_load_en, flags_wr_en, flags_wr_legacy} = '0;
		{gpr_wr_idx, gpr_rd_idx, seg_wr_idx, seg_rd_idx, dbg_idx, instr_len} = '0;
		{gpr_wr_data, seg_wr_data, ip_load_data, flags_wr_data, low_word_data} = '0;
		{ctl_wr_en, load_low_word_instr, ctl_wr_idx, ctl_wr_data, sys_wr_en, sys_wr_data} = '0;
		{dbg_wr_en, tst_wr_en, tst_idx, dbg_wr_data, tst_wr_data, watch_addr} = '0;
		{watch_is_fetch, watch_valid, sh_data, sh_amount} = '0;
		{dq_push_valid, dq_push_data, dq_pop_ready} = '0;
		gpr_wr_view = CARF_VIEW_WORD;
		gpr_rd_view = CARF_VIEW_WORD;
		sys_wr_sel = CARF_SYS_GLOBAL;
		sh_op = CARF_SH_SHL;
		for (i = 0; i < 8; i++) begin
			g[i] = 32'h00000000;
			s[i] = 16'h0000;
			d[i] = 32'h00000000;
		end
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk(extended_status_word, `CARF_FLAGS_RESET, "flags reset");
		chk(instr_pointer, `CARF_IP_RESET, "pointer reset");
		chk(real_mode, 1'b1, "starts in real mode");
		chk({dq_push_ready, dq_pop_valid}, 2'h2, "queue empty");
		// Random sub-view writes, read back through the same view on the first four registers and as a word on the rest.
		gpr_wr_en = 1'b1;
		for (i = 0; i < 48; i++) begin
			r = xs();
			gpr_wr_idx = (i < 8) ? i[2:0] : r[2:0];
			gpr_wr_view = (i < 8) ? CARF_VIEW_HIGH_BYTE : carf_view_t'(r[4:3]);
			gpr_wr_data = xs();
			step();
			k = gpr_wr_idx;
			g[k] = upd(g[k], gpr_wr_view, gpr_wr_data, k);
			gpr_rd_idx = gpr_wr_idx;
			gpr_rd_view = (k < 4) ? gpr_wr_view : CARF_VIEW_WORD;
			#1 chk(gpr_rd_data, rdv(g[k], gpr_rd_view), "sub-view");
		end
		gpr_wr_en = 1'b0;
		gpr_rd_view = CARF_VIEW_WORD;
		for (i = 0; i < 8; i++) begin
			gpr_rd_idx = i[2:0];
			#1 chk(gpr_rd_data, g[i], "general word");
		end
		chk({accumulator_gpr, base_gpr}, {g[0], g[1]}, "acc base");
		chk({count_gpr, data_ext_gpr}, {g[2], g[3]}, "count data");
		seg_wr_en = 1'b1;
		for (i = 0; i < 16; i++) begin
			r = xs();
			seg_wr_idx = r[2:0];
			seg_wr_data = r[31:16];
			step();
			if (r[2:0] < 3'h6) s[r[2:0]] = r[31:16];
			seg_rd_idx = r[2:0];
			#1 chk(seg_rd_data, (r[2:0] < 3'h6) ? s[r[2:0]] : 16'h0000, "selector");
		end
		seg_wr_en = 1'b0;
		// Back-to-back instruction completions with one load racing a completion.
		e = `CARF_IP_RESET;
		instr_done = 1'b1;
		for (i = 0; i < 8; i++) begin
			r = xs();
			instr_len = r[3:0];
			ip_load_en = (i == 5);
			ip_load_data = r;
			step();
			e = (i == 5) ? r : e + {28'h0000000, r[3:0]};
			chk(instr_pointer, e, "pointer advance");
		end
		{instr_done, ip_load_en} = 2'b00;
		step();
		chk(instr_pointer, e, "pointer hold");
		r = xs();
		flags_wr_en = 1'b1;
		flags_wr_data = r;
		step();
		flags_wr_legacy = 1'b1;
		flags_wr_data = ~r;
		step();
		flags_wr_en = 1'b0;
		chk(extended_status_word, {r[31:16], ~r[15:0]}, "legacy flags write");
		chk(legacy_status_word, {48'h0, ~r[15:0]}, "legacy flags view");
		ctl(1'b1, 2'h0, 32'h00000011, 1'b0, 16'h0000, 32'h00000011);
		ctl(1'b0, 2'h0, 32'h00000000, 1'b1, 16'hABCE, 32'h0000ABCF);
		ctl(1'b1, 2'h0, 32'h12340000, 1'b0, 16'h0000, 32'h12340000);
		ctl(1'b0, 2'h0, 32'h00000000, 1'b1, 16'h0001, 32'h12340001);
		ctl(1'b1, 2'h0, 32'hFFFF0000, 1'b1, 16'h0003, 32'hFFFF0000);
		p[0] = xs();
		p[1] = xs();
		ctl(1'b1, 2'h1, p[0], 1'b0, 16'h0000, 32'hFFFF0000);
		ctl(1'b1, 2'h2, p[1], 1'b0, 16'h0000, 32'hFFFF0000);
		ctl(1'b1, 2'h3, xs(), 1'b0, 16'h0000, 32'hFFFF0000);
		ctl(1'b0, 2'h0, 32'h00000000, 1'b0, 16'h0000, 32'hFFFF0000);
		chk({fault_address_reg, page_dir_base_reg}, {p[0], p[1]}, "paging regs");
		sys_wr_en = 1'b1;
		for (i = 0; i < 4; i++) begin
			sys_wr_sel = carf_sys_sel_t'(i[1:0]);
			p[i] = xs();
			sys_wr_data = p[i];
			step();
		end
		sys_wr_en = 1'b0;
		chk({global_table_pointer, vector_table_pointer}, {p[0], p[1]}, "tables");
		chk({local_table_pointer, task_state_pointer}, {p[2], p[3]}, "local task");
		dbg_wr_en = 1'b1;
		for (i = 0; i < 8; i++) begin
			dbg_idx = i[2:0];
			dbg_wr_data = (i == 4) ? 32'h0000004D : xs();
			if (i < 6) d[i] = dbg_wr_data;
			step();
		end
		dbg_wr_en = 1'b0;
		for (i = 0; i < 8; i++) begin
			dbg_idx = i[2:0];
			#1 chk(dbg_rd_data, d[i], "debug read");
		end
		p[0] = xs();
		tst_wr_en = 1'b1;
		tst_wr_data = p[0];
		step();
		tst_idx = 1'b1;
		tst_wr_data = ~p[0];
		step();
		tst_wr_en = 1'b0;
		chk({tst_cmd, tst_data}, {p[0], ~p[0]}, "test regs");
		for (i = 0; i < 10; i++) begin
			watch_valid = (i < 8);
			watch_is_fetch = i[0];
			watch_addr = d[i[2:1]];
			#1 chk(bkp_hit, bkx(watch_addr, watch_is_fetch, watch_valid), "breakpoint");
		end
		watch_valid = 1'b0;
		for (i = 0; i < 20; i++) begin
			r = xs();
			sh_data = {xs(), xs()};
			sh_amount = (i == 0) ? 6'h00 : ((i == 1) ? 6'h3F : r[5:0]);
			sh_op = carf_shift_op_t'(3'(i % 5));
			#1 chk(sh_result, shx(sh_data, sh_amount, sh_op), "shifter");
		end
		// Fill the queue while the consumer stalls, then drain it in order.
		dq_push_valid = 1'b1;
		for (i = 0; i < 5; i++) begin
			p[i % 4] = (i < 4) ? xs() : p[i % 4];
			dq_push_data = (i < 4) ? p[i] : ~p[0];
			#1 chk(dq_push_ready, i < 4, "push ready");
			step();
		end
		dq_push_valid = 1'b0;
		dq_pop_ready = 1'b1;
		for (i = 0; i < 4; i++) begin
			#1 chk({dq_pop_valid, dq_pop_data}, {1'b1, p[i]}, "queue order");
			step();
		end
		#1 chk({dq_pop_valid, dq_push_ready}, 2'h1, "queue drained");
		report_and_stop();
	end
endmodule : carf_register_file_tb
